// ---- design/tssc_task_switch.sv ----
// Task state segment save, load and descriptor check engine
//
// The APB slave port and the register addresses were left to the implementer.
module tssc_task_switch (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Status
  output logic             switch_active,
  output logic             general_protection_fault,
  output logic             invalid_state_segment_fault,
  output logic             debug_trap
);
  import tssc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_DLO = 4'b0001, S_DHI = 4'b0011, S_CHECK = 4'b0010,
    S_SAVE = 4'b0110, S_OHI = 4'b0111, S_OWR = 4'b0101, S_LOAD = 4'b0100,
    S_LINK = 4'b1100, S_NWR = 4'b1101, S_DONE = 4'b1111, S_FAULT = 4'b1110
  } tssc_st_t;

  typedef struct packed {
    tssc_st_t                    st;
    logic [4:0]                  idx;
    logic                        req;
    logic                        we;
    logic [31:0]                 addr;
    logic [31:0]                 wdata;
    logic [31:0]                 dlo;
    logic [31:0]                 dhi;
    logic [31:0]                 ohi;
    tssc_kind_t                  kind;
    logic                        m64;
    logic [1:0]                  priv;
    logic [15:0]                 nsel;
    logic [31:0]                 gtbl;
    logic [15:0]                 trsel;
    logic [31:0]                 trbase;
    logic [31:0]                 trlim;
    logic [5:0]                  stat;
    logic                        ready;
    logic                        act;
    logic [31:0]                 prdata;
    logic                        slverr;
    logic [CTX_WORDS-1:0][31:0]  ctx;
  } tssc_state_t;

  tssc_state_t s_r;
  tssc_state_t s_nxt;

  logic        gp_c;
  logic        ts_c;
  logic        np_c;
  logic        io_dn_c;
  logic        callish;
  logic        wr_acc;
  logic        done;
  logic        mem_st;
  logic        mem_w;
  logic [31:0] mem_a;
  logic [31:0] mem_d;
  logic [31:0] nbase;
  logic [31:0] odesc;
  logic [31:0] ndesc;
  logic [4:0]  ridx;
  logic [5:0]  clr;

  // ----------------------------------------------------------------
  // Checkers
  // ----------------------------------------------------------------
  tssc_desc_check u_desc (
    .kind                        (s_r.kind),
    .local_table_select          (s_r.nsel[2]),
    .mode64                      (s_r.m64),
    .current_privilege_level     (s_r.priv),
    .desc_lo                     (s_r.dlo),
    .desc_hi                     (s_r.dhi),
    .general_protection_fault    (gp_c),
    .invalid_state_segment_fault (ts_c),
    .not_present_fault           (np_c)
  );

  // Bitmap base lives in the upper half of the last loaded word
  tssc_io_limit u_io (
    .io_map_base   (s_r.ctx[IDX_TRAP][31:16]),
    .io_port       (pwdata[15:0]),
    .segment_limit (s_r.trlim),
    .io_denied     (io_dn_c)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt   = s_r;
    callish = (s_r.kind == K_CALL) || (s_r.kind == K_INTR) || (s_r.kind == K_EXC);
    wr_acc  = psel && penable && s_r.ready && pwrite;
    done    = s_r.req && mem_ack;
    nbase   = {s_r.dhi[31:24], s_r.dhi[7:0], s_r.dlo[31:16]};
    odesc   = s_r.gtbl + {16'h0, s_r.trsel[15:3], 3'b000};
    ndesc   = s_r.gtbl + {16'h0, s_r.nsel[15:3], 3'b000};
    ridx    = paddr[6:2];
    clr     = 6'h00;
    mem_st  = 1'b0;
    mem_w   = 1'b0;
    mem_a   = 32'h0000_0000;
    mem_d   = 32'h0000_0000;

    // APB: one wait-free access, data prepared in the setup cycle
    s_nxt.ready  = psel && !penable;
    s_nxt.slverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        A_CTRL:   s_nxt.prdata = {25'h0, s_r.priv, s_r.m64, s_r.kind, s_r.st != S_IDLE};
        A_NEWSEL: s_nxt.prdata = {16'h0, s_r.nsel};
        A_GTBL:   s_nxt.prdata = s_r.gtbl;
        A_STAT:   s_nxt.prdata = {26'h0, s_r.stat};
        A_TRSEL:  s_nxt.prdata = {16'h0, s_r.trsel};
        A_TRBASE: s_nxt.prdata = s_r.trbase;
        A_TRLIM:  s_nxt.prdata = s_r.trlim;
        A_IOCHK:  s_nxt.prdata = 32'h0000_0000;
        default: begin
          if (paddr[11:8] == A_CTX_PG && !paddr[7] && ridx <= IDX_LAST)
            s_nxt.prdata = s_r.ctx[ridx];
          else
            s_nxt.slverr = 1'b1;
        end
      endcase
    end

    // APB writes; control and context are frozen while a switch runs
    if (wr_acc) begin
      unique case (paddr)
        A_CTRL: begin
          if (s_r.st == S_IDLE) begin
            s_nxt.kind = tssc_kind_t'(pwdata[3:1]);
            s_nxt.m64  = pwdata[4];
            s_nxt.priv = pwdata[6:5];
            if (pwdata[0])
              s_nxt.st = S_DLO;
          end
        end
        A_NEWSEL: if (s_r.st == S_IDLE) s_nxt.nsel = pwdata[15:0];
        A_GTBL:   if (s_r.st == S_IDLE) s_nxt.gtbl = pwdata;
        A_STAT:   clr = pwdata[5:0];
        A_IOCHK:  s_nxt.stat[ST_IODN] = io_dn_c;
        default: begin
          if (paddr[11:8] == A_CTX_PG && !paddr[7] && ridx <= IDX_LAST
              && s_r.st == S_IDLE)
            s_nxt.ctx[ridx] = pwdata;
        end
      endcase
    end
    // Write-one clears; sequencer sets below override them
    s_nxt.stat = s_nxt.stat & ~clr;

    // Switch sequencer
    unique case (s_r.st)
      S_IDLE: begin
      end
      S_DLO: begin
        mem_st = 1'b1;
        mem_a  = ndesc;
        if (done) begin
          s_nxt.dlo = mem_rdata;
          s_nxt.st  = S_DHI;
        end
      end
      S_DHI: begin
        mem_st = 1'b1;
        mem_a  = ndesc + 32'h0000_0004;
        if (done) begin
          s_nxt.dhi = mem_rdata;
          s_nxt.st  = S_CHECK;
        end
      end
      S_CHECK: begin
        if (gp_c || ts_c || np_c) begin
          s_nxt.stat[ST_GP] = gp_c;
          s_nxt.stat[ST_TS] = ts_c;
          s_nxt.stat[ST_NP] = np_c;
          s_nxt.st = S_FAULT;
        end else if (s_r.kind == K_SEGLD) begin
          s_nxt.stat[ST_DONE] = 1'b1;
          s_nxt.st = S_IDLE;
        end else begin
          s_nxt.idx = IDX_IPTR;
          s_nxt.st  = S_SAVE;
        end
      end
      S_SAVE: begin
        // Dynamic words only; stack, paging root and table fields untouched
        mem_st = 1'b1;
        mem_w  = 1'b1;
        mem_a  = s_r.trbase + {25'h0, s_r.idx, 2'b00};
        mem_d  = s_r.ctx[s_r.idx];
        if (s_r.idx == IDX_FLAGS && s_r.kind == K_RETI)
          mem_d[NEST_BIT] = 1'b0;
        if (done) begin
          s_nxt.idx = s_r.idx + 5'd1;
          if (s_r.idx == IDX_GS)
            s_nxt.st = S_OHI;
        end
      end
      S_OHI: begin
        if (s_r.kind == K_JMP || s_r.kind == K_RETI) begin
          mem_st = 1'b1;
          mem_a  = odesc + 32'h0000_0004;
          if (done) begin
            s_nxt.ohi = mem_rdata;
            s_nxt.st  = S_OWR;
          end
        end else begin
          s_nxt.idx = IDX_LINK;
          s_nxt.st  = S_LOAD;
        end
      end
      S_OWR: begin
        mem_st = 1'b1;
        mem_w  = 1'b1;
        mem_a  = odesc + 32'h0000_0004;
        mem_d  = s_r.ohi;
        mem_d[BUSY_BIT] = 1'b0;
        if (done) begin
          s_nxt.idx = IDX_LINK;
          s_nxt.st  = S_LOAD;
        end
      end
      S_LOAD: begin
        // Static fields read here, no write path back to them
        mem_st = 1'b1;
        mem_a  = nbase + {25'h0, s_r.idx, 2'b00};
        if (done) begin
          s_nxt.ctx[s_r.idx] = mem_rdata;
          s_nxt.idx = s_r.idx + 5'd1;
          if (s_r.idx == IDX_LAST) begin
            s_nxt.st = S_LINK;
            if (callish)
              s_nxt.ctx[IDX_FLAGS][NEST_BIT] = 1'b1;
          end
        end
      end
      S_LINK: begin
        if (callish) begin
          mem_st = 1'b1;
          mem_w  = 1'b1;
          mem_a  = nbase;
          mem_d  = {16'h0, s_r.trsel};
          if (done) begin
            s_nxt.ctx[IDX_LINK] = {16'h0, s_r.trsel};
            s_nxt.st = S_NWR;
          end
        end else begin
          s_nxt.st = S_NWR;
        end
      end
      S_NWR: begin
        if (s_r.kind != K_RETI) begin
          mem_st = 1'b1;
          mem_w  = 1'b1;
          mem_a  = ndesc + 32'h0000_0004;
          mem_d  = s_r.dhi;
          mem_d[BUSY_BIT] = 1'b1;
          if (done)
            s_nxt.st = S_DONE;
        end else begin
          s_nxt.st = S_DONE;
        end
      end
      S_DONE: begin
        // Task register now points at the incoming segment
        s_nxt.trsel  = s_r.nsel;
        s_nxt.trbase = nbase;
        s_nxt.trlim  = s_r.dhi[23] ? {s_r.dhi[19:16], s_r.dlo[15:0], PAGE_FILL}
                                   : {12'h000, s_r.dhi[19:16], s_r.dlo[15:0]};
        s_nxt.stat[ST_DONE] = 1'b1;
        if (s_r.ctx[IDX_TRAP][TRAP_BIT])
          s_nxt.stat[ST_TRAP] = 1'b1;
        s_nxt.st = S_IDLE;
      end
      S_FAULT: begin
        s_nxt.st = S_IDLE;
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase

    // Activity flag kept in a flop so the status pin never glitches
    s_nxt.act = (s_nxt.st != S_IDLE);

    // Memory handshake: request held until acknowledged
    if (done)
      s_nxt.req = 1'b0;
    else if (mem_st && !s_r.req) begin
      s_nxt.req   = 1'b1;
      s_nxt.we    = mem_w;
      s_nxt.addr  = mem_a;
      s_nxt.wdata = mem_d;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.st    <= S_IDLE;
      s_r.kind  <= K_JMP;
      s_r.trlim <= TR_LIM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign pready                      = s_r.ready;
  assign prdata                      = s_r.prdata;
  assign pslverr                     = s_r.slverr;
  assign mem_req                     = s_r.req;
  assign mem_we                      = s_r.we;
  assign mem_addr                    = s_r.addr;
  assign mem_wdata                   = s_r.wdata;
  assign switch_active               = s_r.act;
  assign general_protection_fault    = s_r.stat[ST_GP];
  assign invalid_state_segment_fault = s_r.stat[ST_TS];
  assign debug_trap                  = s_r.stat[ST_TRAP];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_save_window: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.req && s_r.st == S_SAVE |-> s_r.we && s_r.idx >= IDX_IPTR && s_r.idx <= IDX_GS
      && s_r.addr == s_r.trbase + {25'h0, s_r.idx, 2'b00})
    else $error("save outside dynamic words");
  a_link_kind: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.req && s_r.st == S_LINK |-> s_r.kind inside {K_CALL, K_INTR, K_EXC})
    else $error("link written on wrong switch kind");
  a_local_sel: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.st == S_CHECK && s_r.nsel[2] && s_r.kind == K_RETI && !s_r.m64
      |=> s_r.st == S_FAULT && s_r.stat[ST_TS])
    else $error("local selector not refused");
  a_min_limit: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.st == S_CHECK && s_r.kind != K_SEGLD && !s_r.dhi[23]
      && {s_r.dhi[19:16], s_r.dlo[15:0]} < MIN_LIMIT |=> s_r.st == S_FAULT)
    else $error("short segment accepted");
  a_busy_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.req && s_r.st == S_OWR |-> !s_r.wdata[BUSY_BIT]
      && s_r.kind inside {K_JMP, K_RETI})
    else $error("old busy bit handling wrong");
  a_nested_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.st == S_LOAD && $past(s_r.st) == S_LOAD ##0 s_nxt.st == S_LINK ##1
      (s_r.kind inside {K_CALL, K_INTR, K_EXC}) |-> s_r.ctx[IDX_FLAGS][NEST_BIT])
    else $error("nested flag not set");
  a_no_64bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.st == S_CHECK && s_r.m64 && s_r.kind != K_SEGLD
      |=> s_r.st == S_FAULT ##1 s_r.st == S_IDLE)
    else $error("switch in 64-bit mode");
  a_dpl_gate: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.st == S_CHECK && s_r.kind == K_CALL && s_r.priv > s_r.dhi[14:13]
      |=> s_r.stat[ST_GP])
    else $error("privilege check missed");
  a_trap_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.stat[ST_TRAP]) |-> $past(s_r.st) == S_DONE
      && s_r.ctx[IDX_TRAP][TRAP_BIT])
    else $error("debug trap without cause");
endmodule

// ---- common/tssc_pkg.sv ----
// Package: state segment layout, register map, codes and status bits
package tssc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_NEWSEL  = 12'h004;
  localparam logic [11:0] A_GTBL    = 12'h008;
  localparam logic [11:0] A_STAT    = 12'h00C;
  localparam logic [11:0] A_TRSEL   = 12'h010;
  localparam logic [11:0] A_TRBASE  = 12'h014;
  localparam logic [11:0] A_TRLIM   = 12'h018;
  localparam logic [11:0] A_IOCHK   = 12'h01C;
  localparam logic [3:0]  A_CTX_PG  = 4'h1;
  // ----------------------------------------------------------------
  // State segment word indices (byte offset = 4 * index)
  // ----------------------------------------------------------------
  localparam int          CTX_WORDS = 26;
  localparam logic [4:0]  IDX_LINK  = 5'd0;
  localparam logic [4:0]  IDX_PDB   = 5'd7;
  localparam logic [4:0]  IDX_IPTR  = 5'd8;
  localparam logic [4:0]  IDX_FLAGS = 5'd9;
  localparam logic [4:0]  IDX_GS    = 5'd23;
  localparam logic [4:0]  IDX_LTSEL = 5'd24;
  localparam logic [4:0]  IDX_TRAP  = 5'd25;
  localparam logic [4:0]  IDX_LAST  = 5'd25;
  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int          NEST_BIT  = 14;
  localparam int          BUSY_BIT  = 9;
  localparam int          TRAP_BIT  = 0;
  localparam logic [3:0]  TYPE_AVAIL = 4'h9;
  localparam logic [3:0]  TYPE_BUSY  = 4'hB;
  localparam logic [19:0] MIN_LIMIT  = 20'h0_0067;
  localparam logic [31:0] TR_LIM_RST = 32'h0000_FFFF;
  localparam logic [11:0] PAGE_FILL  = 12'hFFF;
  // Status bits
  localparam int          ST_DONE = 0;
  localparam int          ST_GP   = 1;
  localparam int          ST_TS   = 2;
  localparam int          ST_NP   = 3;
  localparam int          ST_TRAP = 4;
  localparam int          ST_IODN = 5;

  typedef enum logic [2:0] {
    K_JMP = 3'd0, K_CALL = 3'd1, K_RETI = 3'd2, K_INTR = 3'd3, K_EXC = 3'd4, K_SEGLD = 3'd5
  } tssc_kind_t;
endpackage

// ---- design/tssc_desc_check.sv ----
// Descriptor validation for the selected state segment
module tssc_desc_check (
  // Request
  input  wire tssc_pkg::tssc_kind_t kind,
  input  wire logic                 local_table_select,
  input  wire logic                 mode64,
  input  wire logic [1:0]           current_privilege_level,
  // Descriptor words
  input  wire logic [31:0]          desc_lo,
  input  wire logic [31:0]          desc_hi,
  // Verdict
  output logic                      general_protection_fault,
  output logic                      invalid_state_segment_fault,
  output logic                      not_present_fault
);
  import tssc_pkg::*;
  logic [19:0] limit;
  logic [3:0]  typ;
  logic        is_seg;
  logic        ret_sw;

  // Priority ladder; the first failing check names the fault
  always_comb begin
    limit  = {desc_hi[19:16], desc_lo[15:0]};
    typ    = desc_hi[11:8];
    is_seg = !desc_hi[12] && (typ == TYPE_AVAIL || typ == TYPE_BUSY);
    ret_sw = (kind == K_RETI);
    general_protection_fault    = 1'b0;
    invalid_state_segment_fault = 1'b0;
    not_present_fault           = 1'b0;
    if (kind == K_SEGLD) begin
      general_protection_fault = is_seg;
    end else if (mode64) begin
      general_protection_fault = 1'b1;
    end else if (local_table_select || !is_seg) begin
      invalid_state_segment_fault = ret_sw;
      general_protection_fault    = !ret_sw;
    end else if ((kind == K_JMP || kind == K_CALL)
                 && current_privilege_level > desc_hi[14:13]) begin
      general_protection_fault = 1'b1;
    end else if (!desc_hi[15]) begin
      not_present_fault = 1'b1;
    end else if (!desc_hi[23] && limit < MIN_LIMIT) begin
      invalid_state_segment_fault = 1'b1;
    end else if (ret_sw ? (typ != TYPE_BUSY) : (typ != TYPE_AVAIL)) begin
      invalid_state_segment_fault = ret_sw;
      general_protection_fault    = !ret_sw;
    end
  end
endmodule

// ---- design/tssc_io_limit.sv ----
// Limit check for a byte of the I/O permission bitmap
module tssc_io_limit (
  // Inputs
  input  wire logic [15:0] io_map_base,
  input  wire logic [15:0] io_port,
  input  wire logic [31:0] segment_limit,
  // Verdict
  output logic             io_denied
);
  logic [16:0] byte_off;

  // Bitmap byte for the port must lie inside the segment limit
  always_comb begin
    byte_off  = {1'b0, io_map_base} + {4'h0, io_port[15:3]};
    io_denied = ({15'h0, byte_off} > segment_limit);
  end
endmodule

// ---- sim/tssc_mem_model.sv ----
// Word memory standing behind the block's memory port
module tssc_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] m [256];
  logic [1:0]  cnt;
  logic        slow;
  // Prompt and slow answers alternate; released data is flipped, never left valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt       <= 2'd0;
      slow      <= 1'b0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req) begin
      cnt <= cnt + 2'd1;
      if (cnt == (slow ? 2'd3 : 2'd0)) begin
        mem_ack <= 1'b1;
        cnt     <= 2'd0;
        slow    <= ~slow;
        if (mem_we) m[mem_addr[9:2]] <= mem_wdata;
        else mem_rdata <= m[mem_addr[9:2]];
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
// Testbench: task switches and descriptor checks driven over APB
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tssc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd_v, prdata, mem_addr, mem_wdata, mem_rdata;
  logic        sl, pready, pslverr, mem_req, mem_we, mem_ack, sw_act, gp, ts, dbg;
  int          num_errors = 0, n_tests = 0;
  // Rows: selector, kind, 64-bit mode, privilege, expected status, status mask
  localparam logic [27:0] FT [7] = '{{16'h000C, K_CALL, 1'b0, 2'd0, 3'b010, 3'b111},
    {16'h000C, K_RETI, 1'b0, 2'd0, 3'b100, 3'b111}, {16'h0010, K_JMP, 1'b0, 2'd0, 3'b100, 3'b111},
    {16'h0018, K_JMP, 1'b0, 2'd3, 3'b010, 3'b111}, {16'h0008, K_SEGLD, 1'b0, 2'd0, 3'b010, 3'b111},
    {16'h0008, K_CALL, 1'b0, 2'd0, 3'b010, 3'b111}, {16'h0010, K_CALL, 1'b1, 2'd0, 3'b000, 3'b001}};
  always #10 pclk = ~pclk;
  tssc_task_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .switch_active(sw_act),
    .general_protection_fault(gp), .invalid_state_segment_fault(ts), .debug_trap(dbg));
  tssc_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request stays put until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    sl   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp);
  endtask
  // Start a switch, wait for the sequencer to go idle, leave status in rd_v
  task automatic sw(input logic [15:0] s, input logic [2:0] k, input logic m6, input logic [1:0] c);
    apb(1'b1, A_NEWSEL, {16'h0000, s});
    apb(1'b1, A_CTRL, {25'h0, c, m6, k, 1'b1});
    @(posedge pclk);
    for (int i = 0; i < 3000 && sw_act === 1'b1; i++) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0000_0000);
  endtask
  function automatic logic [31:0] dh(input logic [1:0] pl, input logic [3:0] ty);
    return {16'h0000, 1'b1, pl, 1'b0, ty, 8'h00};
  endfunction
  // Watchdog: the whole run needs far fewer cycles than this
  initial begin
    #1_000_000;
    num_errors++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 26; i++) begin
      mem.m[i]      = 32'h5555_0000 + i;
      mem.m[64 + i] = 32'h6666_0000 + i;
      mem.m[96 + i] = 32'h7777_0000 + i;
    end
    mem.m[73]  = 32'h0000_0002;
    mem.m[89]  = 32'h0060_0001;
    mem.m[128] = 32'h0000_0067;
    mem.m[129] = dh(2'd0, TYPE_BUSY);
    mem.m[130] = 32'h0100_0067;
    mem.m[131] = dh(2'd3, TYPE_AVAIL);
    mem.m[132] = 32'h0180_0066;
    mem.m[133] = dh(2'd0, TYPE_AVAIL);
    mem.m[134] = 32'h0180_0067;
    mem.m[135] = dh(2'd0, TYPE_AVAIL);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(A_TRSEL, 32'h0000_0000);
    rc(A_TRBASE, 32'h0000_0000);
    rc(A_TRLIM, TR_LIM_RST);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, sl}, 32'h0000_0001);
    apb(1'b1, A_GTBL, 32'h0000_0200);
    for (int i = 8; i < 24; i++) apb(1'b1, 12'(12'h100 + 4 * i), 32'hA000_0000 + i);
    sw(16'h0008, K_CALL, 1'b0, 2'd0);
    chk(rd_v & 32'h0000_003F, 32'h0000_0011);
    chk({31'h0, dbg}, 32'h0000_0001);
    for (int i = 8; i < 24; i++) chk(mem.m[i], 32'hA000_0000 + i);
    for (int i = 1; i < 7; i++) chk(mem.m[i], 32'h5555_0000 + i);
    chk(mem.m[64], 32'h0000_0000);
    chk(mem.m[71], 32'h6666_0007);
    chk(mem.m[88], 32'h6666_0018);
    chk(mem.m[131], dh(2'd3, TYPE_BUSY));
    chk(mem.m[129], dh(2'd0, TYPE_BUSY));
    rc(12'h124, 32'h0000_4002);
    rc(A_TRLIM, 32'h0000_0067);
    apb(1'b1, A_STAT, 32'h0000_003F);
    apb(1'b1, A_IOCHK, 32'h0000_0038);
    apb(1'b0, A_STAT, 32'h0000_0000);
    chk({31'h0, rd_v[ST_IODN]}, 32'h0000_0000);
    apb(1'b1, A_IOCHK, 32'h0000_0040);
    apb(1'b0, A_STAT, 32'h0000_0000);
    chk({31'h0, rd_v[ST_IODN]}, 32'h0000_0001);
    // Refused switches: rows 0 to 5 leave only their GP or TS fault bit behind; the 64-bit row checks only that done stays clear
    for (int r = 0; r < 7; r++) begin
      apb(1'b1, A_STAT, 32'h0000_003F);
      sw(FT[r][27:12], FT[r][11:9], FT[r][8], FT[r][7:6]);
      chk({29'h0, rd_v[2:0] & FT[r][2:0]}, {29'h0, FT[r][5:3]});
      chk({31'h0, gp & FT[r][1]}, {31'h0, FT[r][4]});
      chk({31'h0, ts & FT[r][2]}, {31'h0, FT[r][5]});
    end
    rc(A_TRSEL, 32'h0000_0008);
    sw(16'h0018, K_JMP, 1'b0, 2'd0);
    chk({31'h0, rd_v[ST_DONE]}, 32'h0000_0001);
    chk(mem.m[131], dh(2'd3, TYPE_AVAIL));
    chk(mem.m[135], dh(2'd0, TYPE_BUSY));
    chk(mem.m[96], 32'h7777_0000);
    results();
  end
endmodule
